// *** inc/asp_map.svh ***
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
// Register byte offsets
`define ASP_RX_CTRL     8'h00
`define ASP_TX_CTRL     8'h04
`define ASP_STATUS      8'h08
`define ASP_SLOT_SEL    8'h0C
`define ASP_RX_DATA     8'h10
`define ASP_TX_DATA     8'h14
// Control field positions
`define ASP_FMT_MSB     2
`define ASP_FMT_LSB     0
`define ASP_JW_MSB      4
`define ASP_JW_LSB      3
`define ASP_BPOL        5
`define ASP_LPOL        6
`define ASP_MST         7
`define ASP_RATE_MSB    9
`define ASP_RATE_LSB    8
`define ASP_RXSEL_MSB   2
`define ASP_RXSEL_LSB   0
`define ASP_TXSEL_MSB   6
`define ASP_TXSEL_LSB   4
`define ASP_MST_STAT    16
// Reset values: two-channel I2S, slave, normal polarity
`define ASP_RX_CTRL_RST 7'h00
`define ASP_TX_CTRL_RST 10'h000
// Word geometry
`define ASP_WORD_MAX    5'h18
`define ASP_SLOT_BITS   8'h20
`define ASP_RJ_W24      5'h18
`define ASP_RJ_W20      5'h14
`define ASP_RJ_W18      5'h12
`define ASP_RJ_W16      5'h10
`define ASP_FRAME_2CH   8'h3F
`define ASP_FRAME_TDM   8'hFF
`define ASP_HALF_TDM    8'h80
// Master bit clock half period, system clocks, two-channel frame of 64 bits
`define ASP_DIV_48      8
`define ASP_DIV_96      4
`define ASP_DIV_192     2
`endif

// *** inc/asp_pkg.sv ***
package asp_pkg;
    typedef enum logic [2:0] {
        ASP_FMT_I2S       = 3'h0,
        ASP_FMT_LJ        = 3'h1,
        ASP_FMT_RJ        = 3'h2,
        ASP_FMT_TDM_CLK   = 3'h3,
        ASP_FMT_TDM_PULSE = 3'h4
    } asp_fmt_t;
    typedef enum logic [1:0] {
        ASP_FS_48  = 2'h0,
        ASP_FS_96  = 2'h1,
        ASP_FS_192 = 2'h2
    } asp_rate_t;
endpackage

// *** hw/asp_serial_ports.sv ***
`timescale 1ns/1ns
`include "asp_map.svh"
// Summary of operation
// - Each port selects two-channel stereo or eight-slot TDM, both directions.
// - Sample words are twos complement, most significant bit first.
// - Left word always comes before right word in a two-channel frame.
// - TDM slots 0-3 fill the first frame half, slots 4-7 the second.
// - Non right-justified words accept up to 24 bits; extra bits silently dropped.
// - TDM receive takes the whole stream on data line zero only.
// - TDM receive frame signal may be a 50/50 clock or one-bit pulse.
// - Transmit master allowed except TDM at 192 kHz, which is slave only.
// - Right-justified transmit delays the MSB by 8, 12 or 16 bit clocks.
// - After reset every port setting selects two-channel I2S.
// - Receive clocks are always inputs; transmit clocks are master or slave.
// - Four receive lines use receive clocks; four transmit lines use transmit clocks.
// - A slave ADC runs from our master transmit clocks looped to receive clocks.
// - An external DAC is served by the transmit port alone.
// - I2S frame starts falling, MSB one bit later; LJ/RJ start rising; data changes falling.
// - TDM clock frames start falling, pulse frames rising; MSB one bit later.
// - Polarity, format, clock type settings apply in master and slave; rate applies in master only.
module asp_serial_ports #(
    parameter int unsigned DIV_48  = `ASP_DIV_48,
    parameter int unsigned DIV_96  = `ASP_DIV_96,
    parameter int unsigned DIV_192 = `ASP_DIV_192
) (
    input  wire logic        clock,                // System clock
    input  wire logic        arst_n,               // Async reset
    input  wire logic [7:0]  paddr,                // APB address
    input  wire logic        psel,                 // APB select
    input  wire logic        penable,              // APB enable
    input  wire logic        pwrite,               // APB direction
    input  wire logic [31:0] pwdata,               // APB write data
    output logic      [31:0] prdata,               // APB read data
    output logic             pready,               // APB ready
    output logic             pslverr,              // APB error
    input  wire logic [3:0]  serial_rx_data_line,  // Receive data lines
    input  wire logic        rx_frame_clk,         // Receive frame clock
    input  wire logic        rx_bit_clk,           // Receive bit clock
    output logic      [3:0]  serial_tx_data_line,  // Transmit data lines
    input  wire logic        tx_frame_clk_in,      // Transmit frame clock pin in
    output logic             tx_frame_clk_out,     // Transmit frame clock pin out
    output logic             tx_frame_clk_oe,      // Transmit frame clock drive
    input  wire logic        tx_bit_clk_in,        // Transmit bit clock pin in
    output logic             tx_bit_clk_out,       // Transmit bit clock pin out
    output logic             tx_bit_clk_oe         // Transmit bit clock drive
);

    function automatic logic [4:0] word_len(input logic [2:0] fmt, input logic [1:0] jw,
                                            input logic tx);
        word_len = `ASP_WORD_MAX;
        if (fmt == asp_pkg::ASP_FMT_RJ) begin
            case (jw)
                2'h0:    word_len = `ASP_RJ_W24;
                2'h1:    word_len = `ASP_RJ_W20;
                2'h2:    word_len = tx ? `ASP_RJ_W16 : `ASP_RJ_W18;
                default: word_len = `ASP_RJ_W16;
            endcase
        end
    endfunction

    // Bit position of a word relative to its MSB; wraps large when before it
    function automatic logic [7:0] word_pos(input logic [2:0] fmt, input logic [7:0] cnt,
                                            input logic [4:0] len);
        case (fmt)
            asp_pkg::ASP_FMT_LJ: word_pos = cnt;
            asp_pkg::ASP_FMT_RJ: word_pos = cnt - (`ASP_SLOT_BITS - {3'h0, len});
            default:             word_pos = cnt - 8'h01;
        endcase
    endfunction

    function automatic logic restart(input logic [2:0] fmt, input logic rose,
                                     input logic fell);
        case (fmt)
            asp_pkg::ASP_FMT_TDM_CLK:   restart = fell;
            asp_pkg::ASP_FMT_TDM_PULSE: restart = rose;
            default:                    restart = rose | fell;
        endcase
    endfunction

    // Right channel when set: I2S left while low, LJ/RJ left while high
    function automatic logic right_ch(input logic [2:0] fmt, input logic lvl);
        right_ch = (fmt == asp_pkg::ASP_FMT_I2S) ? lvl : ~lvl;
    endfunction

    function automatic logic master_lr(input logic [2:0] fmt, input logic [7:0] cnt);
        case (fmt)
            asp_pkg::ASP_FMT_I2S:       master_lr = cnt[5];
            asp_pkg::ASP_FMT_TDM_CLK:   master_lr = cnt >= `ASP_HALF_TDM;
            asp_pkg::ASP_FMT_TDM_PULSE: master_lr = cnt == 8'h00;
            default:                    master_lr = ~cnt[5];
        endcase
    endfunction

    logic [6:0]  rx_ctrl_q, rx_ctrl_d;
    logic [9:0]  tx_ctrl_q, tx_ctrl_d;
    logic [2:0]  rx_sel_q, rx_sel_d, tx_sel_q, tx_sel_d;
    logic [23:0] tx_mem_q [8];
    logic [23:0] tx_mem_d [8];
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d, pslverr_q, pslverr_d;

    logic [7:0]  sync1_q, sync2_q, prev_q;
    logic [7:0]  pins;

    logic [23:0] rx_mem_q [8];
    logic [23:0] rx_mem_d [8];
    logic [23:0] rx_sh_q [4];
    logic [23:0] rx_sh_d [4];
    logic [7:0]  rx_cnt_q, rx_cnt_d;
    logic [2:0]  rx_idx_q, rx_idx_d;
    logic        rx_have_q, rx_have_d, rx_lr_last_q, rx_lr_last_d;
    logic [15:0] rx_frames_q, rx_frames_d;

    logic [7:0]  div_q, div_d, mcnt_q, mcnt_d, tx_cnt_q, tx_cnt_d;
    logic        mbclk_q, mbclk_d, mlr_q, mlr_d, tx_lr_last_q, tx_lr_last_d;
    logic [3:0]  tx_out_q, tx_out_d;
    logic        fclk_q, fclk_d, bclk_q, bclk_d, oe_q, oe_d;

    logic [2:0]  rx_fmt, tx_fmt;
    logic        rx_tdm, tx_tdm, mst_eff;
    logic [4:0]  rx_len, tx_len;
    logic [7:0]  half;

    assign rx_fmt  = rx_ctrl_q[`ASP_FMT_MSB:`ASP_FMT_LSB];
    assign tx_fmt  = tx_ctrl_q[`ASP_FMT_MSB:`ASP_FMT_LSB];
    assign rx_tdm  = rx_fmt >= asp_pkg::ASP_FMT_TDM_CLK;
    assign tx_tdm  = tx_fmt >= asp_pkg::ASP_FMT_TDM_CLK;
    assign rx_len  = word_len(rx_fmt, rx_ctrl_q[`ASP_JW_MSB:`ASP_JW_LSB], 1'b0);
    assign tx_len  = word_len(tx_fmt, tx_ctrl_q[`ASP_JW_MSB:`ASP_JW_LSB], 1'b1);
    // TDM at the top rate falls back to slave: the divider cannot reach it
    assign mst_eff = tx_ctrl_q[`ASP_MST] &&
                     !(tx_tdm && tx_ctrl_q[`ASP_RATE_MSB:`ASP_RATE_LSB] ==
                       asp_pkg::ASP_FS_192);

    // Pins are asynchronous to the system clock; two flops before use
    assign pins = {tx_bit_clk_in, tx_frame_clk_in, rx_bit_clk, rx_frame_clk,
                   serial_rx_data_line};

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            prev_q  <= 8'h00;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // APB slave: one wait state so read data comes from a flop
    always_comb begin
        logic acc;
        logic hit;
        acc       = psel && penable;
        hit       = 1'b1;
        rx_ctrl_d = rx_ctrl_q;
        tx_ctrl_d = tx_ctrl_q;
        rx_sel_d  = rx_sel_q;
        tx_sel_d  = tx_sel_q;
        tx_mem_d  = tx_mem_q;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        pready_d  = acc && !pready_q;
        if (paddr == `ASP_RX_CTRL) begin
            prdata_d = {25'h0, rx_ctrl_q};
        end else if (paddr == `ASP_TX_CTRL) begin
            prdata_d = {22'h0, tx_ctrl_q};
        end else if (paddr == `ASP_STATUS) begin
            prdata_d = {15'h0, mst_eff, rx_frames_q};
        end else if (paddr == `ASP_SLOT_SEL) begin
            prdata_d = {25'h0, tx_sel_q, 1'b0, rx_sel_q};
        end else if (paddr == `ASP_RX_DATA) begin
            prdata_d = {{8{rx_mem_q[rx_sel_q][23]}}, rx_mem_q[rx_sel_q]};
        end else if (paddr == `ASP_TX_DATA) begin
            prdata_d = {{8{tx_mem_q[tx_sel_q][23]}}, tx_mem_q[tx_sel_q]};
        end else begin
            hit      = 1'b0;
            prdata_d = 32'h0000_0000;
        end
        if (acc && !pready_q) begin
            pslverr_d = !hit;
            if (pwrite) begin
                prdata_d = 32'h0000_0000;
            end
        end
        if (acc && pready_q && pwrite) begin
            if (paddr == `ASP_RX_CTRL) begin
                rx_ctrl_d = pwdata[6:0];
            end else if (paddr == `ASP_TX_CTRL) begin
                tx_ctrl_d = pwdata[9:0];
            end else if (paddr == `ASP_SLOT_SEL) begin
                rx_sel_d = pwdata[`ASP_RXSEL_MSB:`ASP_RXSEL_LSB];
                tx_sel_d = pwdata[`ASP_TXSEL_MSB:`ASP_TXSEL_LSB];
            end else if (paddr == `ASP_TX_DATA) begin
                tx_mem_d[tx_sel_q] = pwdata[23:0];
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_ctrl_q <= `ASP_RX_CTRL_RST;
            tx_ctrl_q <= `ASP_TX_CTRL_RST;
            rx_sel_q  <= 3'h0;
            tx_sel_q  <= 3'h0;
            tx_mem_q  <= '{default: 24'h000000};
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            rx_ctrl_q <= rx_ctrl_d;
            tx_ctrl_q <= tx_ctrl_d;
            rx_sel_q  <= rx_sel_d;
            tx_sel_q  <= tx_sel_d;
            tx_mem_q  <= tx_mem_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Receive: slave only, sample on rising bit clock edge
    always_comb begin
        logic       bclk;
        logic       bprev;
        logic       lr;
        logic [7:0] cnt;
        logic [7:0] pos;
        logic       ok;
        logic [2:0] idx;
        bclk         = sync2_q[5] ^ rx_ctrl_q[`ASP_BPOL];
        bprev        = prev_q[5] ^ rx_ctrl_q[`ASP_BPOL];
        lr           = sync2_q[4] ^ rx_ctrl_q[`ASP_LPOL];
        cnt          = rx_cnt_q;
        pos          = 8'h00;
        ok           = 1'b0;
        idx          = 3'h0;
        rx_cnt_d     = rx_cnt_q;
        rx_idx_d     = rx_idx_q;
        rx_have_d    = rx_have_q;
        rx_lr_last_d = rx_lr_last_q;
        rx_frames_d  = rx_frames_q;
        rx_mem_d     = rx_mem_q;
        rx_sh_d      = rx_sh_q;
        if (bclk && !bprev) begin
            rx_lr_last_d = lr;
            // Pulse frames restart on the rising edge only, clock frames on falling
            cnt = restart(rx_fmt, lr && !rx_lr_last_q, !lr && rx_lr_last_q) ?
                  8'h00 : rx_cnt_q + 8'h01;
            rx_cnt_d = cnt;
            pos = word_pos(rx_fmt, cnt, rx_len);
            ok  = rx_tdm || pos[7:5] == 3'h0;
            idx = rx_tdm ? pos[7:5] : {2'h0, right_ch(rx_fmt, lr)};
            if (ok && pos[4:0] == 5'h00) begin
                if (rx_have_q) begin
                    for (int l = 0; l < 4; l++) begin
                        if (rx_tdm && l == 0) begin
                            rx_mem_d[rx_idx_q] = rx_sh_q[0];
                        end else if (!rx_tdm) begin
                            rx_mem_d[{rx_idx_q[0], 2'(l)}] = rx_sh_q[l];
                        end
                    end
                end
                rx_have_d = 1'b1;
                rx_idx_d  = idx;
                rx_sh_d   = '{default: 24'h000000};
                if (idx == 3'h0) begin
                    rx_frames_d = rx_frames_q + 16'h0001;
                end
            end
            if (ok && pos[4:0] < rx_len) begin
                for (int l = 0; l < 4; l++) begin
                    rx_sh_d[l][5'h17 - pos[4:0]] = sync2_q[l];
                end
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_mem_q     <= '{default: 24'h000000};
            rx_sh_q      <= '{default: 24'h000000};
            rx_cnt_q     <= 8'h00;
            rx_idx_q     <= 3'h0;
            rx_have_q    <= 1'b0;
            rx_lr_last_q <= 1'b0;
            rx_frames_q  <= 16'h0000;
        end else begin
            rx_mem_q     <= rx_mem_d;
            rx_sh_q      <= rx_sh_d;
            rx_cnt_q     <= rx_cnt_d;
            rx_idx_q     <= rx_idx_d;
            rx_have_q    <= rx_have_d;
            rx_lr_last_q <= rx_lr_last_d;
            rx_frames_q  <= rx_frames_d;
        end
    end

    // Master half period per rate; TDM carries four times the bits per frame
    always_comb begin
        case (tx_ctrl_q[`ASP_RATE_MSB:`ASP_RATE_LSB])
            asp_pkg::ASP_FS_48: half = 8'(DIV_48);
            asp_pkg::ASP_FS_96: half = 8'(DIV_96);
            default:            half = 8'(DIV_192);
        endcase
        if (tx_tdm) begin
            half = half >> 2;
        end
        if (half == 8'h00) begin
            half = 8'h01;
        end
    end

    // Transmit: clocks made here or taken from the pins; data changes on fall
    always_comb begin
        logic       fall;
        logic       lr;
        logic [7:0] cnt;
        logic [7:0] pos;
        logic       ch;
        logic [4:0] bi;
        fall         = 1'b0;
        lr           = 1'b0;
        cnt          = tx_cnt_q;
        pos          = 8'h00;
        ch           = 1'b0;
        bi           = 5'h00;
        div_d        = 8'h00;
        mbclk_d      = mbclk_q;
        mcnt_d       = mcnt_q;
        mlr_d        = mlr_q;
        tx_cnt_d     = tx_cnt_q;
        tx_lr_last_d = tx_lr_last_q;
        tx_out_d     = tx_out_q;
        if (mst_eff) begin
            div_d = div_q + 8'h01;
            if (div_q >= half - 8'h01) begin
                div_d   = 8'h00;
                mbclk_d = !mbclk_q;
                if (mbclk_q) begin
                    fall   = 1'b1;
                    mcnt_d = (mcnt_q == (tx_tdm ? `ASP_FRAME_TDM : `ASP_FRAME_2CH)) ?
                             8'h00 : mcnt_q + 8'h01;
                    mlr_d  = master_lr(tx_fmt, mcnt_d);
                end
            end
            lr = mlr_d;
        end else begin
            mbclk_d = 1'b0;
            mcnt_d  = `ASP_FRAME_TDM;
            fall    = !(sync2_q[7] ^ tx_ctrl_q[`ASP_BPOL]) &&
                      (prev_q[7] ^ tx_ctrl_q[`ASP_BPOL]);
            lr      = sync2_q[6] ^ tx_ctrl_q[`ASP_LPOL];
        end
        if (fall) begin
            tx_lr_last_d = lr;
            cnt = restart(tx_fmt, lr && !tx_lr_last_q, !lr && tx_lr_last_q) ?
                  8'h00 : tx_cnt_q + 8'h01;
            tx_cnt_d = cnt;
            pos = word_pos(tx_fmt, cnt, tx_len);
            ch  = right_ch(tx_fmt, lr);
            bi  = 5'h17 - pos[4:0];
            for (int l = 0; l < 4; l++) begin
                tx_out_d[l] = 1'b0;
                if ((tx_tdm || pos[7:5] == 3'h0) && pos[4:0] < tx_len) begin
                    if (tx_tdm) begin
                        tx_out_d[l] = (l == 0) && tx_mem_q[pos[7:5]][bi];
                    end else begin
                        tx_out_d[l] = tx_mem_q[{ch, 2'(l)}][bi];
                    end
                end
            end
        end
        bclk_d = mbclk_d ^ tx_ctrl_q[`ASP_BPOL];
        fclk_d = mlr_d ^ tx_ctrl_q[`ASP_LPOL];
        oe_d   = mst_eff;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_q        <= 8'h00;
            mbclk_q      <= 1'b0;
            mcnt_q       <= `ASP_FRAME_TDM;
            mlr_q        <= 1'b0;
            tx_cnt_q     <= 8'h00;
            tx_lr_last_q <= 1'b0;
            tx_out_q     <= 4'h0;
            bclk_q       <= 1'b0;
            fclk_q       <= 1'b0;
            oe_q         <= 1'b0;
        end else begin
            div_q        <= div_d;
            mbclk_q      <= mbclk_d;
            mcnt_q       <= mcnt_d;
            mlr_q        <= mlr_d;
            tx_cnt_q     <= tx_cnt_d;
            tx_lr_last_q <= tx_lr_last_d;
            tx_out_q     <= tx_out_d;
            bclk_q       <= bclk_d;
            fclk_q       <= fclk_d;
            oe_q         <= oe_d;
        end
    end

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign serial_tx_data_line = tx_out_q;
    assign tx_bit_clk_out      = bclk_q;
    assign tx_frame_clk_out    = fclk_q;
    assign tx_bit_clk_oe       = oe_q;
    assign tx_frame_clk_oe     = oe_q;

endmodule // asp_serial_ports

// *** sim/asp_monitor.sv ***
`timescale 1ns/1ns
`include "asp_map.svh"
module asp_monitor (
    input wire logic        clock,               // Clock
    input wire logic        arst_n,              // Reset
    input wire logic [7:0]  paddr,               // Address
    input wire logic        psel,                // Select
    input wire logic        penable,             // Enable
    input wire logic        pwrite,              // Write
    input wire logic [31:0] pwdata,              // Write data
    input wire logic        pready,              // Ready
    input wire logic        pslverr,             // Error
    input wire logic [3:0]  serial_tx_data_line, // Tx data
    input wire logic        tx_bit_clk_out,      // Tx bit clock
    input wire logic        tx_frame_clk_out,    // Tx frame clock
    input wire logic        tx_bit_clk_oe,       // Bit clock drive
    input wire logic        tx_frame_clk_oe      // Frame clock drive
);
    logic [9:0] ctl_q;
    logic [9:0] ctl_d;
    always_comb begin
        ctl_d = ctl_q;
        if (psel && penable && pready && pwrite && !pslverr && paddr == `ASP_TX_CTRL) begin
            ctl_d = pwdata[9:0];
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= `ASP_TX_CTRL_RST;
        end else begin
            ctl_q <= ctl_d;
        end
    end
    // Mirror of the last accepted transmit setting; outputs lag it by a flop
    wire tdm   = ctl_q[2:0] inside {3'h3, 3'h4};
    wire slow  = tdm && ctl_q[9:8] == 2'h2;
    wire drv   = ctl_q[7] && !slow;
    wire plain = drv && !tdm && !ctl_q[5];
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready not given after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_align: assert property (
        psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access not refused");
    a_slow_slave: assert property (slow [*3] |-> !tx_bit_clk_oe && !tx_frame_clk_oe)
        else $error("clocks driven in fast slot mode");
    a_master_drive: assert property (drv [*3] |-> tx_bit_clk_oe && tx_frame_clk_oe)
        else $error("master clocks not driven");
    a_slave_release: assert property (
        !ctl_q[7] [*3] |-> !tx_bit_clk_oe && !tx_frame_clk_oe)
        else $error("slave drives clocks");
    a_frame_on_fall: assert property (
        plain [*4] ##0 $changed(tx_frame_clk_out) |-> $fell(tx_bit_clk_out))
        else $error("frame clock moved off bit clock fall");
    a_data_bclk_low: assert property (
        plain [*4] ##0 $changed(serial_tx_data_line) |-> !tx_bit_clk_out)
        else $error("data changed while bit clock high");
    c_master: cover property (drv ##1 tx_bit_clk_oe);
    c_refused: cover property (pslverr);
    c_slow: cover property (slow [*3]);
endmodule // asp_monitor

bind asp_serial_ports asp_monitor u_mon (
    .clock(clock), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .serial_tx_data_line(serial_tx_data_line), .tx_bit_clk_out(tx_bit_clk_out),
    .tx_frame_clk_out(tx_frame_clk_out), .tx_bit_clk_oe(tx_bit_clk_oe),
    .tx_frame_clk_oe(tx_frame_clk_oe)
);

// *** sim/asp_codec.sv ***
`timescale 1ns/1ns
module asp_codec (
    input  wire logic         run,    // Send frames while high
    input  wire logic [191:0] words,  // Eight words, index {ch,line}
    output logic              bclk,   // Bit clock
    output logic              lrclk,  // Frame clock
    output logic [3:0]        sdata   // Data lines
);
    int p;
    int i;
    initial begin
        bclk = 1'b0;
        lrclk = 1'b1;
        sdata = 4'h0;
        forever begin
            wait (run);
            #5; // Keep link edges clear of the system clock edge
            for (p = 0; p < 64; p++) begin
                bclk = 1'b0;
                lrclk = p >= 32;
                // Slot bit 0 and bits past 24 toggle so dropped bits are visible
                for (i = 0; i < 4; i++) begin
                    sdata[i] = (p % 32 >= 1 && p % 32 <= 24) ?
                        words[24 * (i + 4 * (p / 32)) + 24 - p % 32] : ~sdata[i];
                end
                #80 bclk = 1'b1;
                #80;
            end
        end
    end
endmodule // asp_codec

// *** sim/testbench.sv ***
`timescale 1ns/1ns
`include "asp_map.svh"
module testbench;
    logic         clock, arst_n, psel, penable, pwrite, pready, pslverr;
    logic         rx_lr, rx_bc, t_lr, t_bc, boe, run, err;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rd, seed;
    logic [3:0]   rxd, txd;
    logic [191:0] words;
    logic [23:0]  tv, got;
    int           fail_count, tests_run;
    asp_serial_ports dut (
        .clock(clock), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_rx_data_line(rxd), .rx_frame_clk(rx_lr), .rx_bit_clk(rx_bc),
        .serial_tx_data_line(txd), .tx_frame_clk_in(rx_lr), .tx_frame_clk_out(t_lr),
        .tx_frame_clk_oe(), .tx_bit_clk_in(rx_bc), .tx_bit_clk_out(t_bc), .tx_bit_clk_oe(boe)
    );
    asp_codec adc (.run(run), .words(words), .bclk(rx_bc), .lrclk(rx_lr), .sdata(rxd));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] sx(input logic [23:0] w);
        return {{8{w[23]}}, w};
    endfunction
    task automatic end_of_test();
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fail_count++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits for a frame clock fall (fr=1) or a bit clock rise (fr=0)
    task automatic edge_wait(input logic fr);
        logic a;
        logic b;
        a = fr ? t_lr : t_bc;
        for (int n = 0; n < 3000; n++) begin
            @(posedge clock);
            b = fr ? t_lr : t_bc;
            if (fr ? (a && !b) : (!a && b)) return;
            a = b;
        end
        fail_count++;
        end_of_test();
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        {arst_n, psel, penable, pwrite, run} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        words = 192'h0;
        seed = 32'h5D50;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        apb(1'b0, `ASP_RX_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `ASP_TX_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 8'h02, 32'h7);
        chk({31'h0, err}, 32'h1);
        $display("test reset and map done");
        for (int k = 0; k < 8; k++) words[24 * k +: 24] <= 24'(xs());
        @(posedge clock);
        words[23:0] <= 24'h800000;
        words[191:168] <= 24'h7FFFFF;
        run <= 1'b1;
        // Drop run inside frame two so exactly two frames go out
        repeat (600) @(posedge clock);
        run <= 1'b0;
        repeat (600) @(posedge clock);
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, `ASP_SLOT_SEL, 32'(k));
            apb(1'b0, `ASP_RX_DATA, 32'h0);
            chk(rd, sx(words[24 * k +: 24]));
        end
        // Two frames went out, each starting one index 0 word
        apb(1'b0, `ASP_STATUS, 32'h0);
        chk(rd, 32'h2);
        $display("test receive done");
        tv = 24'(xs());
        apb(1'b1, `ASP_SLOT_SEL, 32'h0);
        apb(1'b1, `ASP_TX_DATA, {8'h0, tv});
        apb(1'b1, `ASP_TX_CTRL, 32'h80);
        apb(1'b0, `ASP_TX_DATA, 32'h0);
        chk(rd, sx(tv));
        edge_wait(1'b1);
        edge_wait(1'b1);
        for (int j = 0; j < 25; j++) begin
            edge_wait(1'b0);
            if (j > 0) got[24 - j] = txd[0];
        end
        chk({8'h0, got}, {8'h0, tv});
        chk({31'h0, boe}, 32'h1);
        $display("test transmit done");
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, `ASP_TX_CTRL, 32'h80 + 32'((k % 3) * 256 + (k > 2 ? 3 : 0)));
            apb(1'b0, `ASP_STATUS, 32'h0);
            chk({31'h0, rd[16]}, {31'h0, !(k == 5)});
        end
        $display("test master rates done");
        end_of_test();
    end
endmodule // testbench
